// >>> src/general_mask_control.sv
// general mask control register pair with interrupt gating and event qualification
`timescale 1ns/1ps
module general_mask_control
(
	input  wire logic                                   clock,
	input  wire logic                                   resetn,
	input  wire logic                                   regWrite,
	input  wire logic                                   regRead,
	input  wire logic [7:0]                             cmdCode,
	input  wire logic                                   busAddressLsb,
	input  wire logic [15:0]                            wrData,
	output logic      [15:0]                            rdData,
	output logic                                        busAck,
	output logic                                        accessWide,
	output logic                                        multiLevelPriority,
	input  wire logic [gmc_pkg::NUM_CH-1:0]             irqSource,
	input  wire logic [gmc_pkg::NUM_CH-1:0]             irqMask,
	output logic                                        intPinOut,
	output logic                                        intPinOeN,
	input  wire logic [gmc_pkg::NUM_CH-1:0]             detDone,
	input  wire logic [gmc_pkg::NUM_CH*gmc_pkg::RES_W-1:0] detResult,
	input  wire logic [gmc_pkg::NUM_CH-1:0]             clsDone,
	input  wire logic [gmc_pkg::NUM_CH*gmc_pkg::RES_W-1:0] clsResult,
	input  wire logic [gmc_pkg::NUM_CH-1:0]             detectEventClear,
	input  wire logic [gmc_pkg::NUM_CH-1:0]             classEventClear,
	output logic      [gmc_pkg::NUM_CH-1:0]             detectEventFlag,
	output logic      [gmc_pkg::NUM_CH-1:0]             classEventFlag
);
	chan_event_if ev ();

	logic [7:0]                  genMaskLo_r;
	logic [7:0]                  genMaskHi_r;
	logic [15:0]                 rdData_r;
	logic                        busAck_r;
	logic                        intPinOeN_r;
	logic                        intPinOut_r;
	logic [gmc_pkg::NUM_CH-1:0]  detFlag_r;
	logic [gmc_pkg::NUM_CH-1:0]  clsFlag_r;
	logic [gmc_pkg::NUM_CH-1:0]  irqGate;
	logic [gmc_pkg::NUM_CH-1:0]  detChg;
	logic [gmc_pkg::NUM_CH-1:0]  clsChg;

	// the channel 1-4 copy alone decides the bus width for both halves
	wire wideMode   = genMaskLo_r[gmc_pkg::BIT_ACCESS_WIDE];
	wire cmdHit     = cmdCode == gmc_pkg::CMD_GEN_MASK;
	// in wide mode the odd address is not ours and goes unanswered
	wire addrOk     = ~wideMode | ~busAddressLsb;
	wire accessHit  = cmdHit & addrOk & (regWrite | regRead);
	wire wrLo       = cmdHit & addrOk & regWrite & (wideMode | ~busAddressLsb);
	wire wrHi       = cmdHit & addrOk & regWrite & (wideMode | busAddressLsb);
	wire [7:0] wrLoByte = wrData[7:0];
	wire [7:0] wrHiByte = wideMode ? wrData[15:8] : wrData[7:0];
	wire [7:0] narrowByte = busAddressLsb ? genMaskHi_r : genMaskLo_r;
	wire [15:0] rdValue = wideMode ? {genMaskHi_r, genMaskLo_r} : {gmc_pkg::BYTE_ZERO, narrowByte};
	// each four-channel group is gated by the gate bit of its own register copy
	wire irqAny     = |(irqSource & ~irqMask & irqGate);

	genvar ch;
	generate
		for (ch = 0; ch < gmc_pkg::NUM_CH; ch++)
		begin : g_ch
			wire [7:0] own = (ch < gmc_pkg::CH_PER_HALF) ? genMaskLo_r : genMaskHi_r;
			assign irqGate[ch]          = own[gmc_pkg::BIT_IRQ_GATE];
			assign detChg[ch]           = own[gmc_pkg::BIT_DETECT_CHG];
			assign clsChg[ch]           = own[gmc_pkg::BIT_CLASS_CHG];
			assign ev.detResult[ch]     = detResult[ch*gmc_pkg::RES_W +: gmc_pkg::RES_W];
			assign ev.clsResult[ch]     = clsResult[ch*gmc_pkg::RES_W +: gmc_pkg::RES_W];
		end
	endgenerate

	assign ev.detDone       = detDone;
	assign ev.clsDone       = clsDone;
	assign ev.detChangeOnly = detChg;
	assign ev.clsChangeOnly = clsChg;

	event_qualifier u_qual
	(
		.clock  (clock),
		.resetn (resetn),
		.ev     (ev.qual)
	);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			genMaskLo_r <= gmc_pkg::GEN_MASK_RESET;
		else if (wrLo)
			genMaskLo_r <= wrLoByte;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			genMaskHi_r <= gmc_pkg::GEN_MASK_RESET;
		else if (wrHi)
			genMaskHi_r <= wrHiByte;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rdData_r <= 16'h0000;
			busAck_r <= 1'b0;
		end
		else
		begin
			busAck_r <= accessHit;
			if (cmdHit & addrOk & regRead)
				rdData_r <= rdValue;
		end
	end

	// open-drain pin: enable low pulls the line to its active low level
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			intPinOeN_r <= 1'b1;
			intPinOut_r <= 1'b0;
		end
		else
		begin
			intPinOeN_r <= ~irqAny;
			intPinOut_r <= 1'b0;
		end
	end

	// flags ignore the gate bit; a set in the clearing cycle survives the clear
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			detFlag_r <= '0;
			clsFlag_r <= '0;
		end
		else
		begin
			detFlag_r <= (detFlag_r & ~detectEventClear) | ev.detSet;
			clsFlag_r <= (clsFlag_r & ~classEventClear) | ev.clsSet;
		end
	end

	assign rdData             = rdData_r;
	assign busAck             = busAck_r;
	assign accessWide         = genMaskLo_r[gmc_pkg::BIT_ACCESS_WIDE];
	// the shutdown decoder follows the 3-bit priority registers when this is high
	assign multiLevelPriority = genMaskLo_r[gmc_pkg::BIT_MULTI_PRIO];
	assign intPinOut          = intPinOut_r;
	assign intPinOeN          = intPinOeN_r;
	assign detectEventFlag    = detFlag_r;
	assign classEventFlag     = clsFlag_r;
endmodule

// >>> include/gmc_pkg.sv
// constants for the general mask control register bank
package gmc_pkg;
	localparam int          NUM_CH          = 8;
	localparam int          NUM_HALF        = 2;
	localparam int          CH_PER_HALF     = 4;
	localparam int          RES_W           = 4;
	localparam logic [7:0]  CMD_GEN_MASK    = 8'h17;
	localparam logic [7:0]  GEN_MASK_RESET  = 8'h80;
	localparam int          BIT_IRQ_GATE    = 7;
	localparam int          BIT_ACCESS_WIDE = 5;
	localparam int          BIT_MULTI_PRIO  = 4;
	localparam int          BIT_CLASS_CHG   = 3;
	localparam int          BIT_DETECT_CHG  = 2;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [RES_W-1:0] RESULT_RESET = 4'h0;
	// the fast-shutdown idle time that the host keeps before raising the priority mode
	localparam int          OSS_IDLE_US     = 200;
	localparam int          CLOCK_MHZ       = 40;
	localparam int          OSS_IDLE_CYCLES = OSS_IDLE_US * CLOCK_MHZ;
endpackage

// >>> include/chan_event_if.sv
// per-channel detection and classification completions and their qualified set pulses
`timescale 1ns/1ps
interface chan_event_if;
	logic [gmc_pkg::NUM_CH-1:0]                   detDone;
	logic [gmc_pkg::NUM_CH-1:0][gmc_pkg::RES_W-1:0] detResult;
	logic [gmc_pkg::NUM_CH-1:0]                   clsDone;
	logic [gmc_pkg::NUM_CH-1:0][gmc_pkg::RES_W-1:0] clsResult;
	logic [gmc_pkg::NUM_CH-1:0]                   detChangeOnly;
	logic [gmc_pkg::NUM_CH-1:0]                   clsChangeOnly;
	logic [gmc_pkg::NUM_CH-1:0]                   detSet;
	logic [gmc_pkg::NUM_CH-1:0]                   clsSet;

	modport top
	(
		output detDone, detResult, clsDone, clsResult, detChangeOnly, clsChangeOnly,
		input  detSet, clsSet
	);
	modport qual
	(
		input  detDone, detResult, clsDone, clsResult, detChangeOnly, clsChangeOnly,
		output detSet, clsSet
	);
endinterface

// >>> src/event_qualifier.sv
// remembers the last detection and class result per channel and qualifies event pulses
`timescale 1ns/1ps
module event_qualifier
(
	input  wire logic     clock,
	input  wire logic     resetn,
	chan_event_if.qual    ev
);
	genvar ch;
	generate
		for (ch = 0; ch < gmc_pkg::NUM_CH; ch++)
		begin : g_ch
			logic [gmc_pkg::RES_W-1:0] prevDet_r;
			logic [gmc_pkg::RES_W-1:0] prevCls_r;
			wire                       detDiffers = ev.detResult[ch] != prevDet_r;
			wire                       clsDiffers = ev.clsResult[ch] != prevCls_r;

			// a change-only channel reports only a differing result
			assign ev.detSet[ch] = ev.detDone[ch] & (~ev.detChangeOnly[ch] | detDiffers);
			assign ev.clsSet[ch] = ev.clsDone[ch] & (~ev.clsChangeOnly[ch] | clsDiffers);

			// history tracks every completion, so a mode switch compares against the true last result
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					prevDet_r <= gmc_pkg::RESULT_RESET;
				else if (ev.detDone[ch])
					prevDet_r <= ev.detResult[ch];
			end

			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					prevCls_r <= gmc_pkg::RESULT_RESET;
				else if (ev.clsDone[ch])
					prevCls_r <= ev.clsResult[ch];
			end
		end
	endgenerate
endmodule

// >>> bench/gmc_properties.sv
// port-level assertions for the general mask control register bank
`timescale 1ns/1ps
module gmc_properties
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  cmdCode,
	input wire logic        busAddressLsb,
	input wire logic [15:0] rdData,
	input wire logic        busAck,
	input wire logic        accessWide,
	input wire logic        multiLevelPriority,
	input wire logic [7:0]  irqSource,
	input wire logic [7:0]  irqMask,
	input wire logic        intPinOut,
	input wire logic        intPinOeN,
	input wire logic [7:0]  detDone,
	input wire logic [7:0]  clsDone,
	input wire logic [7:0]  detectEventClear,
	input wire logic [7:0]  detectEventFlag,
	input wire logic [7:0]  classEventFlag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	wire [7:0] live = irqSource & ~irqMask;

	a_pin_idle: assert property (live == 8'h00 |=> intPinOeN) else $error("pin driven without source");
	a_pin_cause: assert property ($fell(intPinOeN) |-> $past(live) != 8'h00) else $error("pin cause");
	a_pin_data_low: assert property (intPinOut == 1'b0) else $error("pin data not low");
	a_wide_refuse: assert property (accessWide && busAddressLsb && (regWrite || regRead) |=> !busAck) else $error("odd lsb answered");
	a_narrow_ack: assert property ((regWrite || regRead) && cmdCode == 8'h17 && !accessWide |=> busAck) else $error("no answer");
	a_narrow_byte: assert property (regRead && cmdCode == 8'h17 && !accessWide |=> rdData[15:8] == 8'h00) else $error("wide narrow data");
	a_det_cause: assert property ((detectEventFlag & ~$past(detectEventFlag) & ~$past(detDone)) == 8'h00) else $error("det flag");
	a_cls_cause: assert property ((classEventFlag & ~$past(classEventFlag) & ~$past(clsDone)) == 8'h00) else $error("cls flag");
	a_flag_sticky: assert property (($past(detectEventFlag) & ~detectEventFlag & ~$past(detectEventClear)) == 8'h00) else $error("flag lost");
	a_prio_by_write: assert property ($changed(multiLevelPriority) |-> $past(regWrite)) else $error("priority moved");
endmodule

// >>> bench/host_model.sv
// register host issuing one-cycle bus requests
`timescale 1ns/1ps
module host_model
(
	input  wire logic        clock,
	input  wire logic        busAck,
	input  wire logic [15:0] rdData,
	output logic             regWrite,
	output logic             regRead,
	output logic [7:0]       cmdCode,
	output logic             busAddressLsb,
	output logic [15:0]      wrData
);
	initial {regWrite, regRead, cmdCode, busAddressLsb, wrData} = '0;
	task automatic acc(input logic w, input logic [7:0] cmd, input logic lsb, input logic [15:0] d,
		output logic ack, output logic [15:0] q);
		@(negedge clock);
		regWrite      = w;
		regRead       = !w;
		cmdCode       = cmd;
		busAddressLsb = lsb;
		wrData        = d;
		@(negedge clock);
		// the answer stands for this one cycle only, so it is taken before the release
		ack      = busAck;
		q        = rdData;
		regWrite = 1'b0;
		regRead  = 1'b0;
		// released data must not look like the last value
		wrData   = ~d;
	endtask
	// wide mode is enabled from the channel 1-4 address only
	task automatic raise_prio(input logic [15:0] d);
		logic        a;
		logic [15:0] r;
		repeat (gmc_pkg::OSS_IDLE_CYCLES) @(negedge clock); // fast-shutdown line idle first
		acc(1'b1, 8'h17, 1'b0, d, a, r);
	endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the general mask control register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
	typedef struct packed {logic [7:0] gate; logic [7:0] src; logic [7:0] msk; logic oeN;} row_t;
	logic        clock, resetn, regWrite, regRead, busAddressLsb, busAck, accessWide, multiLevelPriority;
	logic        intPinOut, intPinOeN, ack;
	logic [7:0]  cmdCode, irqSource, irqMask, detDone, clsDone, detectEventClear, classEventClear;
	logic [7:0]  detectEventFlag, classEventFlag;
	logic [15:0] wrData, rdData, q;
	logic [31:0] detResult, clsResult;
	int          checks, n_fail;
	row_t        rows [5] = '{'{8'h80, 8'h01, 8'h00, 1'b0}, '{8'h80, 8'h01, 8'h01, 1'b1},
		'{8'h00, 8'hFF, 8'h00, 1'b1}, '{8'h80, 8'h10, 8'h00, 1'b0}, '{8'h80, 8'h00, 8'h00, 1'b1}};

	general_mask_control dut (.*);
	host_model host (.*);

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic ev(input logic cls, input logic [3:0] r, input logic e);
		@(negedge clock);
		{clsDone, detDone} = cls ? 16'h0100 : 16'h0001;
		{clsResult, detResult} = {28'h0, r, 28'h0, r};
		@(negedge clock);
		{clsDone, detDone} = '0;
		{classEventClear, detectEventClear} = 16'hFFFF;
		`CHK("event flag", e, cls ? classEventFlag[0] : detectEventFlag[0])
		@(negedge clock);
		{classEventClear, detectEventClear} = '0;
	endtask

	task conclude;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		{irqSource, irqMask, detDone, clsDone, detectEventClear, classEventClear, detResult, clsResult} = '0;
		resetn = 1'b0;
		repeat (10) @(posedge clock);
		@(negedge clock);
		resetn = 1'b1;
		host.acc(0, 8'h17, 1, 16'h0000, ack, q);
		`CHK("reset copy", 16'h0080, q)
		`CHK("narrow ack", 1'b1, ack)
		`CHK("reset mode", 2'b00, {accessWide, multiLevelPriority})
		foreach (rows[i])
		begin
			host.acc(1, 8'h17, 0, {8'h00, rows[i].gate}, ack, q);
			host.acc(1, 8'h17, 1, {8'h00, rows[i].gate}, ack, q);
			host.acc(0, 8'h17, 1, 16'h0000, ack, q);
			`CHK("half byte", {8'h00, rows[i].gate}, q)
			irqSource = rows[i].src;
			irqMask   = rows[i].msk;
			repeat (2) @(negedge clock);
			`CHK("int pin", rows[i].oeN, intPinOeN)
		end
		host.acc(1, 8'h17, 0, 16'h0000, ack, q);
		ev(0, 4'h5, 1);
		ev(0, 4'h5, 1);
		ev(1, 4'h3, 1);
		ev(1, 4'h3, 1);
		host.acc(1, 8'h17, 0, 16'h000C, ack, q);
		ev(0, 4'h5, 0);
		ev(0, 4'h6, 1);
		ev(1, 4'h3, 0);
		ev(1, 4'h4, 1);
		// a new event in the clearing cycle must keep the flag
		@(negedge clock);
		detDone   = 8'h01;
		detResult = 32'h8;
		@(negedge clock);
		detResult        = 32'h9;
		detectEventClear = 8'h01;
		@(negedge clock);
		{detDone, detectEventClear} = '0;
		`CHK("set beats clear", 1'b1, detectEventFlag[0])
		detectEventClear = 8'h01;
		@(negedge clock);
		detectEventClear = '0;
		`CHK("flag cleared", 1'b0, detectEventFlag[0])
		host.acc(1, 8'h17, 0, 16'h0020, ack, q);
		`CHK("wide bit", 1'b1, accessWide)
		host.acc(1, 8'h17, 0, 16'h8020, ack, q);
		host.acc(0, 8'h17, 0, 16'h0000, ack, q);
		`CHK("wide read", 16'h8020, q)
		`CHK("wide ack", 1'b1, ack)
		host.acc(0, 8'h17, 1, 16'h0000, ack, q);
		`CHK("odd lsb answer", 1'b0, ack)
		host.acc(0, 8'h18, 0, 16'h0000, ack, q);
		`CHK("other code answer", 1'b0, ack)
		host.raise_prio(16'h8030);
		`CHK("priority mode", 1'b1, multiLevelPriority)
		// reset in mid-run must bring back the power-on register image
		@(negedge clock);
		resetn = 1'b0;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		`CHK("reset again", 2'b00, {accessWide, multiLevelPriority})
		host.acc(0, 8'h17, 0, 16'h0000, ack, q);
		`CHK("reset lo copy", 16'h0080, q)
		`CHK("reset lo ack", 1'b1, ack)
		conclude();
	end
endmodule

bind general_mask_control gmc_properties chk (.*);
